// ---- hw/ref_profile_pkg.sv ----
// Constants, field map and byte masks of the reference profile register bank.
// ---------------------------------------------------------------------------
package ref_profile_pkg;

   // Printed register indices; the bus byte address is four times the index.
   localparam int          IDX_W     = 11;
   localparam int          ADDR_LSB  = 2;
   localparam logic [10:0] IDX_P2    = 11'h680;
   localparam logic [10:0] BANK_OFF  = 11'h100;
   localparam int          BANK_BIT  = 8;
   localparam logic [10:0] IDX_A0    = 11'h692;
   localparam logic [10:0] IDX_AEXP  = 11'h694;
   localparam logic [10:0] IDX_B0L   = 11'h695;
   localparam logic [10:0] IDX_B0M   = 11'h696;
   localparam logic [10:0] IDX_B1    = 11'h697;
   localparam logic [10:0] IDX_G0    = 11'h698;
   localparam logic [10:0] IDX_G1    = 11'h69A;
   localparam logic [10:0] IDX_D0    = 11'h69B;
   localparam logic [10:0] IDX_D1    = 11'h69C;
   localparam logic [10:0] IDX_A3    = 11'h69D;
   localparam logic [10:0] IDX_RDIV  = 11'h69E;
   localparam logic [10:0] IDX_RTOP  = 11'h6A1;
   localparam logic [10:0] IDX_SDIV  = 11'h6A2;
   localparam logic [10:0] IDX_STOP  = 11'h6A4;
   localparam logic [10:0] IDX_SSP   = 11'h6A5;
   localparam logic [10:0] IDX_FRAC  = 11'h6A6;
   localparam logic [10:0] IDX_FRM   = 11'h6A7;
   localparam logic [10:0] IDX_FRT   = 11'h6A8;
   localparam logic [10:0] IDX_PTHR  = 11'h6A9;
   localparam logic [10:0] IDX_PFILL = 11'h6AB;
   localparam logic [10:0] IDX_PDRN  = 11'h6AC;
   localparam logic [10:0] IDX_FTHR  = 11'h6AD;
   localparam logic [10:0] IDX_FFILL = 11'h6B0;
   localparam logic [10:0] IDX_FDRN  = 11'h6B1;
   localparam logic [10:0] IDX_P3PRI = 11'h6B2;
   localparam logic [10:0] IDX_PER   = 11'h6B3;
   localparam logic [10:0] IDX_PSP0  = 11'h6B8;
   localparam logic [10:0] IDX_LAST  = 11'h6B9;
   localparam logic [10:0] IDX_STAT  = 11'h6F0;
   localparam int          NK        = 58;

   // Priority byte layout, divider limit and bus answers.
   localparam int          PRI_SCALE = 7;
   localparam int          PROM_LSB  = 3;
   localparam int          PRI_W     = 3;
   localparam int          ST_PRIO   = 2;
   localparam logic [19:0] FB_MIN    = 20'h0_0007;
   localparam logic [1:0]  RESP_OKAY = 2'h0;
   localparam logic [1:0]  RESP_DEC  = 2'h3;

   // Slot of a printed index within one profile pair window.
   function automatic logic [5:0] kx(input logic [10:0] idx);
      return 6'(idx - IDX_P2);
   endfunction

   // Writable bits of each slot; zero bits read back as zero.
   function automatic logic [7:0] byte_mask(input logic [5:0] k);
      if (k == kx(IDX_P2) || k == kx(IDX_P3PRI)) return 8'hBF;
      else if (k < kx(IDX_A0)) return 8'h00;
      else if (k == kx(IDX_B1)) return 8'h7F;
      else if (k == kx(IDX_G1) || k == kx(IDX_RTOP) || k == kx(IDX_FRT)) return 8'h3F;
      else if (k == kx(IDX_STOP)) return 8'h0F;
      else if (k == kx(IDX_FRM)) return 8'hF3;
      else if (k == kx(IDX_SSP) || k >= kx(IDX_PSP0)) return 8'h00;
      else return 8'hFF;
   endfunction

endpackage

// ---- hw/ref_profile_regs.sv ----
// AXI4-Lite register bank holding two copies of the profile 2/3 loop settings.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module ref_profile_regs import ref_profile_pkg::*; #(
   parameter int ADDR_W = 13,
   parameter int NB     = 2
) (
   // Clock and reset.
   input  wire logic               CLK_SYS_IN,
   input  wire logic               RESET_N_IN,
   // AXI4-Lite write channels.
   input  wire logic [ADDR_W-1:0]  AXI_AWADDR_IN,
   input  wire logic               AXI_AWVALID_IN,
   output wire logic               AXI_AWREADY_OUT,
   input  wire logic [31:0]        AXI_WDATA_IN,
   input  wire logic [3:0]         AXI_WSTRB_IN,
   input  wire logic               AXI_WVALID_IN,
   output wire logic               AXI_WREADY_OUT,
   output wire logic [1:0]         AXI_BRESP_OUT,
   output wire logic               AXI_BVALID_OUT,
   input  wire logic               AXI_BREADY_IN,
   // AXI4-Lite read channels.
   input  wire logic [ADDR_W-1:0]  AXI_ARADDR_IN,
   input  wire logic               AXI_ARVALID_IN,
   output wire logic               AXI_ARREADY_OUT,
   output wire logic [31:0]        AXI_RDATA_OUT,
   output wire logic [1:0]         AXI_RRESP_OUT,
   output wire logic               AXI_RVALID_OUT,
   input  wire logic               AXI_RREADY_IN,
   // Active reference flag per bank, from the switchover logic.
   input  wire logic [NB-1:0]      P3_ACTIVE_IN,
   // Loop filter coefficients, one slice per bank.
   output wire logic [NB*16-1:0]   ALPHA0_OUT,
   output wire logic [NB*6-1:0]    ALPHA1_EXP_OUT,
   output wire logic [NB*3-1:0]    ALPHA2_EXP_OUT,
   output wire logic [NB*4-1:0]    ALPHA3_EXP_OUT,
   output wire logic [NB*17-1:0]   BETA0_OUT,
   output wire logic [NB*5-1:0]    BETA1_EXP_OUT,
   output wire logic [NB*17-1:0]   GAMMA0_OUT,
   output wire logic [NB*5-1:0]    GAMMA1_EXP_OUT,
   output wire logic [NB*15-1:0]   DELTA0_OUT,
   output wire logic [NB*5-1:0]    DELTA1_EXP_OUT,
   // Divider ratios and fractional terms.
   output wire logic [NB*31-1:0]   REF_RATIO_OUT,
   output wire logic [NB*21-1:0]   FB_RATIO_OUT,
   output wire logic [NB*10-1:0]   FRAC_A_OUT,
   output wire logic [NB*10-1:0]   FRAC_B_OUT,
   // Lock detector settings.
   output wire logic [NB*16-1:0]   PH_THR_OUT,
   output wire logic [NB-1:0]      PH_THR_NS_OUT,
   output wire logic [NB*8-1:0]    PH_FILL_OUT,
   output wire logic [NB*8-1:0]    PH_DRAIN_OUT,
   output wire logic [NB*24-1:0]   FR_THR_OUT,
   output wire logic [NB*8-1:0]    FR_FILL_OUT,
   output wire logic [NB*8-1:0]    FR_DRAIN_OUT,
   // Following profile: priorities and reference period.
   output wire logic [NB-1:0]      P3_PH_NS_OUT,
   output wire logic [NB*3-1:0]    P3_SEL_PRI_OUT,
   output wire logic [NB*3-1:0]    P3_PROM_PRI_OUT,
   output wire logic [NB*3-1:0]    P3_EFF_PRI_OUT,
   output wire logic [NB*40-1:0]   P3_PERIOD_OUT
);

   // ---------------------------------------------------------------
   // Storage and parameter check
   // ---------------------------------------------------------------

   // Banks are selected by one index bit, so only two fit the map.
   if (ADDR_W < IDX_W + ADDR_LSB || NB != 2) begin : g_bad
      $error("ADDR_W must be at least 13 and NB must be 2.");
   end

   logic [7:0]        m [NB][NK];
   logic              aw_empty_r;
   logic              w_empty_r;
   logic              ar_empty_r;
   logic              bvalid_r;
   logic              rvalid_r;
   logic [1:0]        bresp_r;
   logic [1:0]        rresp_r;
   logic [31:0]       rdata_r;
   logic [IDX_W-1:0]  aw_idx_r;
   logic [7:0]        w_data_r;
   logic              w_en_r;
   wire  [2*NB-1:0]   stat_r;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------

   // Folding the bank bit away lets one compare serve both banks.
   wire [IDX_W-1:0] wf      = aw_idx_r & ~BANK_OFF;
   wire             w_hit   = (wf == IDX_P2) || (wf >= IDX_A0 && wf <= IDX_LAST);
   wire [5:0]       wk      = kx(wf);
   wire             wb      = aw_idx_r[BANK_BIT];
   wire             wr_go   = !aw_empty_r && !w_empty_r && !bvalid_r;
   wire [IDX_W-1:0] ri      = AXI_ARADDR_IN[IDX_W+ADDR_LSB-1:ADDR_LSB];
   wire [IDX_W-1:0] rf      = ri & ~BANK_OFF;
   wire             r_hit   = (rf == IDX_P2) || (rf >= IDX_A0 && rf <= IDX_LAST);
   wire             r_stat  = (ri == IDX_STAT);
   wire [5:0]       rk      = kx(rf);
   wire             rb      = ri[BANK_BIT];
   wire             ar_hs   = AXI_ARVALID_IN && ar_empty_r;
   wire [7:0]       w_val   = w_data_r & byte_mask(wk);

   // Read data; unmapped indices answer zero with a decode error.
   wire [31:0] rdata_nxt = r_stat ? 32'(stat_r) : (r_hit ? 32'(m[rb][rk]) : 32'h0000_0000);
   wire [1:0]  rresp_nxt = (r_hit || r_stat) ? RESP_OKAY : RESP_DEC;

   assign AXI_AWREADY_OUT = aw_empty_r;
   assign AXI_WREADY_OUT  = w_empty_r;
   assign AXI_BVALID_OUT  = bvalid_r;
   assign AXI_BRESP_OUT   = bresp_r;
   assign AXI_ARREADY_OUT = ar_empty_r;
   assign AXI_RVALID_OUT  = rvalid_r;
   assign AXI_RRESP_OUT   = rresp_r;
   assign AXI_RDATA_OUT   = rdata_r;

   // ---------------------------------------------------------------
   // Write channels
   // ---------------------------------------------------------------

   // Address and data are held until both are in, in either order.
   always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         aw_empty_r <= 1'b1;
         w_empty_r  <= 1'b1;
         aw_idx_r   <= '0;
         w_data_r   <= '0;
         w_en_r     <= 1'b0;
      end else if (wr_go) begin
         aw_empty_r <= 1'b1;
         w_empty_r  <= 1'b1;
      end else begin
         if (AXI_AWVALID_IN && aw_empty_r) begin
            aw_idx_r   <= AXI_AWADDR_IN[IDX_W+ADDR_LSB-1:ADDR_LSB];
            aw_empty_r <= 1'b0;
         end
         if (AXI_WVALID_IN && w_empty_r) begin
            w_data_r  <= AXI_WDATA_IN[7:0];
            w_en_r    <= AXI_WSTRB_IN[0];
            w_empty_r <= 1'b0;
         end
      end
   end

   // Response follows the write by one edge and stands until taken.
   always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r  <= (w_hit || aw_idx_r == IDX_STAT) ? RESP_OKAY : RESP_DEC;
      end else if (AXI_BREADY_IN) begin
         bvalid_r <= 1'b0;
      end
   end

   // Byte-wide store; only lane 0 carries data, masked bits stay zero.
   always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         m <= '{default: '{default: 8'h00}};
      end else if (wr_go && w_hit && w_en_r) begin
         m[wb][wk] <= w_val;
      end
   end

   // ---------------------------------------------------------------
   // Read channels
   // ---------------------------------------------------------------

   // Data is sampled at the address handshake, so it answers one edge later.
   always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ar_empty_r <= 1'b1;
         rvalid_r   <= 1'b0;
         rdata_r    <= '0;
         rresp_r    <= RESP_OKAY;
      end else if (ar_hs) begin
         ar_empty_r <= 1'b0;
         rvalid_r   <= 1'b1;
         rdata_r    <= rdata_nxt;
         rresp_r    <= rresp_nxt;
      end else if (rvalid_r && AXI_RREADY_IN) begin
         ar_empty_r <= 1'b1;
         rvalid_r   <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Field assembly per bank
   // ---------------------------------------------------------------

   for (genvar b = 0; b < NB; b++) begin : g_bank
      logic [29:0] r_val;
      logic [19:0] s_val;
      logic [30:0] ref_r;
      logic [20:0] fb_r;
      logic [2:0]  sel;
      logic [2:0]  prom;
      logic [2:0]  eff_r;
      logic        fb_low_r;
      logic        pri_bad_r;

      // Little-endian assembly of the multi-byte fields.
      assign ALPHA0_OUT[b*16 +: 16]   = {m[b][kx(IDX_A0)+1], m[b][kx(IDX_A0)]};
      assign ALPHA1_EXP_OUT[b*6 +: 6] = m[b][kx(IDX_AEXP)][5:0];
      assign ALPHA2_EXP_OUT[b*3 +: 3] = {m[b][kx(IDX_B0L)][0], m[b][kx(IDX_AEXP)][7:6]};
      assign BETA0_OUT[b*17 +: 17]    = {m[b][kx(IDX_B1)][1:0], m[b][kx(IDX_B0M)],
                                         m[b][kx(IDX_B0L)][7:1]};
      assign BETA1_EXP_OUT[b*5 +: 5]  = m[b][kx(IDX_B1)][6:2];
      assign GAMMA0_OUT[b*17 +: 17]   = {m[b][kx(IDX_G1)][0], m[b][kx(IDX_G0)+1],
                                         m[b][kx(IDX_G0)]};
      assign GAMMA1_EXP_OUT[b*5 +: 5] = m[b][kx(IDX_G1)][5:1];
      assign DELTA0_OUT[b*15 +: 15]   = {m[b][kx(IDX_D1)][6:0], m[b][kx(IDX_D0)]};
      assign DELTA1_EXP_OUT[b*5 +: 5] = {m[b][kx(IDX_A3)][3:0], m[b][kx(IDX_D1)][7]};
      assign ALPHA3_EXP_OUT[b*4 +: 4] = m[b][kx(IDX_A3)][7:4];

      // Divider fields; the ratio applied is one above the stored value.
      assign r_val = {m[b][kx(IDX_RTOP)][5:0], m[b][kx(IDX_RDIV)+2], m[b][kx(IDX_RDIV)+1],
                      m[b][kx(IDX_RDIV)]};
      assign s_val = {m[b][kx(IDX_STOP)][3:0], m[b][kx(IDX_SDIV)+1], m[b][kx(IDX_SDIV)]};
      assign FRAC_A_OUT[b*10 +: 10] = {m[b][kx(IDX_FRM)][1:0], m[b][kx(IDX_FRAC)]};
      assign FRAC_B_OUT[b*10 +: 10] = {m[b][kx(IDX_FRT)][5:0], m[b][kx(IDX_FRM)][7:4]};
      assign REF_RATIO_OUT[b*31 +: 31] = ref_r;
      assign FB_RATIO_OUT[b*21 +: 21]  = fb_r;

      // Lock detector settings.
      assign PH_THR_OUT[b*16 +: 16]  = {m[b][kx(IDX_PTHR)+1], m[b][kx(IDX_PTHR)]};
      assign PH_THR_NS_OUT[b]        = m[b][kx(IDX_P2)][PRI_SCALE];
      assign PH_FILL_OUT[b*8 +: 8]   = m[b][kx(IDX_PFILL)];
      assign PH_DRAIN_OUT[b*8 +: 8]  = m[b][kx(IDX_PDRN)];
      assign FR_THR_OUT[b*24 +: 24]  = {m[b][kx(IDX_FTHR)+2], m[b][kx(IDX_FTHR)+1],
                                        m[b][kx(IDX_FTHR)]};
      assign FR_FILL_OUT[b*8 +: 8]   = m[b][kx(IDX_FFILL)];
      assign FR_DRAIN_OUT[b*8 +: 8]  = m[b][kx(IDX_FDRN)];

      // Following profile priorities and period.
      assign sel  = m[b][kx(IDX_P3PRI)][PRI_W-1:0];
      assign prom = m[b][kx(IDX_P3PRI)][PROM_LSB +: PRI_W];
      assign P3_PH_NS_OUT[b]         = m[b][kx(IDX_P3PRI)][PRI_SCALE];
      assign P3_SEL_PRI_OUT[b*3 +: 3]  = sel;
      assign P3_PROM_PRI_OUT[b*3 +: 3] = prom;
      assign P3_EFF_PRI_OUT[b*3 +: 3]  = eff_r;
      assign P3_PERIOD_OUT[b*40 +: 40] = {m[b][kx(IDX_PER)+4], m[b][kx(IDX_PER)+3],
                                          m[b][kx(IDX_PER)+2], m[b][kx(IDX_PER)+1],
                                          m[b][kx(IDX_PER)]};

      // Ratios and priority are registered so downstream sees clean flops.
      always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
         if (!RESET_N_IN) begin
            ref_r <= '0;
            fb_r  <= '0;
            eff_r <= '0;
         end else begin
            ref_r <= 31'(r_val) + 31'(1);
            fb_r  <= 21'(s_val) + 21'(1);
            eff_r <= P3_ACTIVE_IN[b] ? prom : sel;
         end
      end

      // Status flags warn of settings software must avoid; they track live.
      always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
         if (!RESET_N_IN) begin
            fb_low_r  <= 1'b0;
            pri_bad_r <= 1'b0;
         end else begin
            fb_low_r  <= (s_val < FB_MIN);
            pri_bad_r <= (prom > sel);
         end
      end

      // Each bank owns its own bits of the shared status word, so every bit has one driver.
      assign stat_r[b]           = fb_low_r;
      assign stat_r[ST_PRIO + b] = pri_bad_r;
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------

   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RESET_N_IN);

   wire wr_byte = wr_go && w_hit && w_en_r;

   property p_store;
      wr_byte |=> m[$past(wb)][$past(wk)] == $past(w_val);
   endproperty
   a_store: assert property (p_store) else $error("Byte write not stored.");

   property p_spare;
      m[0][kx(IDX_SSP)] == 8'h00 && m[1][kx(IDX_PSP0)] == 8'h00 && !m[0][kx(IDX_B1)][7];
   endproperty
   a_spare: assert property (p_spare) else $error("Unused bits hold a value.");

   property p_alpha0_high;
      wr_byte && !wb && wf == IDX_A0 + 11'(1) |=> ALPHA0_OUT[15:8] == $past(w_data_r);
   endproperty
   a_alpha0_high: assert property (p_alpha0_high) else $error("Alpha-0 high byte wrong.");

   property p_period_top;
      wr_byte && wb && wf == IDX_PER + 11'(4) |=> P3_PERIOD_OUT[79:72] == $past(w_data_r);
   endproperty
   a_period_top: assert property (p_period_top) else $error("Period top byte wrong.");

   property p_ref_ratio;
      ##1 1'b1 |-> REF_RATIO_OUT[30:0] == 31'($past(g_bank[0].r_val)) + 31'(1);
   endproperty
   a_ref_ratio: assert property (p_ref_ratio) else $error("Reference ratio not value plus one.");

   property p_fb_low;
      (g_bank[1].s_val < FB_MIN) |=> stat_r[1] && FB_RATIO_OUT[41:21] == 21'($past(g_bank[1].s_val)) + 21'(1);
   endproperty
   a_fb_low: assert property (p_fb_low) else $error("Feedback limit flag missing.");

   property p_eff_pri;
      P3_ACTIVE_IN[0] |=> P3_EFF_PRI_OUT[2:0] == $past(g_bank[0].prom);
   endproperty
   a_eff_pri: assert property (p_eff_pri) else $error("Promoted priority not applied.");

   // The registered choice lags the bytes by one edge, hence the past value.
   property p_eff_sel;
      !P3_ACTIVE_IN[0] |=> P3_EFF_PRI_OUT[2:0] == $past(g_bank[0].sel);
   endproperty
   a_eff_sel: assert property (p_eff_sel) else $error("Selection priority not applied.");

   property p_bank_apart;
      wr_byte && wb |=> m[0][$past(wk)] == $past(m[0][wk]);
   endproperty
   a_bank_apart: assert property (p_bank_apart) else $error("Bank write leaked across.");

   property p_bresp;
      wr_go |=> bvalid_r ##0 (bresp_r == RESP_OKAY) == $past(w_hit || aw_idx_r == IDX_STAT);
   endproperty
   a_bresp: assert property (p_bresp) else $error("Write response wrong.");

   property p_rd_unmapped;
      ar_hs && !r_hit && !r_stat |=> rvalid_r && rdata_r == 32'h0000_0000 && rresp_r == RESP_DEC;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("Unmapped read not refused.");

   c_bank1_write: cover property (wr_byte && wb);
   c_stat_read: cover property (ar_hs && r_stat ##1 rdata_r != 32'h0000_0000);
   c_dec_write: cover property (wr_go && !w_hit);
   c_promoted: cover property (P3_ACTIVE_IN[1] ##1 P3_EFF_PRI_OUT[5:3] != P3_SEL_PRI_OUT[5:3]);

endmodule

// ---- test/test_reference_profile_register_bank.sv ----
// Self-checking bench for the reference profile register bank over AXI4-Lite.
`timescale 1ns/100ps
module test_reference_profile_register_bank import ref_profile_pkg::*;;
   // ---------------------------------------------------------------------------
   // Signals, named as the ports so the instance connects by name.
   // ---------------------------------------------------------------------------
   logic        CLK_SYS_IN, RESET_N_IN, AXI_AWVALID_IN, AXI_WVALID_IN, AXI_BREADY_IN, AXI_ARVALID_IN, AXI_RREADY_IN;
   logic [12:0] AXI_AWADDR_IN, AXI_ARADDR_IN;
   logic [31:0] AXI_WDATA_IN;
   logic [3:0]  AXI_WSTRB_IN;
   logic [1:0]  P3_ACTIVE_IN;
   wire logic   AXI_AWREADY_OUT, AXI_WREADY_OUT, AXI_BVALID_OUT, AXI_ARREADY_OUT, AXI_RVALID_OUT;
   wire logic [31:0] AXI_RDATA_OUT, ALPHA0_OUT, PH_THR_OUT;
   wire logic [1:0]  AXI_BRESP_OUT, AXI_RRESP_OUT, PH_THR_NS_OUT, P3_PH_NS_OUT;
   wire logic [11:0] ALPHA1_EXP_OUT;
   wire logic [5:0]  ALPHA2_EXP_OUT, P3_SEL_PRI_OUT, P3_PROM_PRI_OUT, P3_EFF_PRI_OUT;
   wire logic [7:0]  ALPHA3_EXP_OUT;
   wire logic [33:0] BETA0_OUT, GAMMA0_OUT;
   wire logic [9:0]  BETA1_EXP_OUT, GAMMA1_EXP_OUT, DELTA1_EXP_OUT;
   wire logic [29:0] DELTA0_OUT;
   wire logic [61:0] REF_RATIO_OUT;
   wire logic [41:0] FB_RATIO_OUT;
   wire logic [19:0] FRAC_A_OUT, FRAC_B_OUT;
   wire logic [15:0] PH_FILL_OUT, PH_DRAIN_OUT, FR_FILL_OUT, FR_DRAIN_OUT;
   wire logic [47:0] FR_THR_OUT;
   wire logic [79:0] P3_PERIOD_OUT;
   int          mismatches, checks_done;
   logic [7:0]  v [0:39];
   logic [1:0]  rsp;
   logic [31:0] rdat;

   ref_profile_regs i_dut (.*);

   // Free-running 40 MHz clock.
   initial begin
      CLK_SYS_IN = 1'b0;
      forever #12.5 CLK_SYS_IN = ~CLK_SYS_IN;
   end

   // ---------------------------------------------------------------------------
   // Bus tasks and comparisons.
   // ---------------------------------------------------------------------------
   // Address and data are offered together and each dropped once taken.
   task automatic wr(input logic [10:0] idx, input logic [7:0] d);
      @(posedge CLK_SYS_IN);
      AXI_AWADDR_IN  <= {idx, 2'b00};
      AXI_WDATA_IN   <= {24'h00_0000, d};
      AXI_AWVALID_IN <= 1'b1;
      AXI_WVALID_IN  <= 1'b1;
      AXI_BREADY_IN  <= 1'b1;
      do begin
         @(posedge CLK_SYS_IN);
         if (AXI_AWREADY_OUT) AXI_AWVALID_IN <= 1'b0;
         if (AXI_WREADY_OUT) AXI_WVALID_IN <= 1'b0;
      end while (AXI_BVALID_OUT !== 1'b1);
      rsp = AXI_BRESP_OUT;
      AXI_BREADY_IN <= 1'b0;
   endtask

   task automatic rd(input logic [10:0] idx);
      @(posedge CLK_SYS_IN);
      AXI_ARADDR_IN  <= {idx, 2'b00};
      AXI_ARVALID_IN <= 1'b1;
      AXI_RREADY_IN  <= 1'b1;
      do begin
         @(posedge CLK_SYS_IN);
         if (AXI_ARREADY_OUT) AXI_ARVALID_IN <= 1'b0;
      end while (AXI_RVALID_OUT !== 1'b1);
      rdat = AXI_RDATA_OUT;
      rsp  = AXI_RRESP_OUT;
      AXI_RREADY_IN <= 1'b0;
   endtask

   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   // A read must answer OKAY with the given byte in the low lane.
   task automatic rdchk(input logic [10:0] idx, input logic [7:0] e);
      rd(idx);
      chk($sformatf("read %h", idx), {24'h00_0000, e}, rdat);
      chk("read resp", RESP_OKAY, rsp);
   endtask

   // Writable bits per slot counted from the alpha-0 low byte.
   function automatic logic [7:0] msk(input int s);
      case (s)
         5:          return 8'h7F;
         8, 15, 22:  return 8'h3F;
         18:         return 8'h0F;
         21:         return 8'hF3;
         32:         return 8'hBF;
         19, 38, 39: return 8'h00;
         default:    return 8'hFF;
      endcase
   endfunction

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Cuts a hang short; the whole sequence needs well under a thousand cycles.
   initial begin
      #(25 * 6000);
      mismatches++;
      final_report;
   end

   // ---------------------------------------------------------------------------
   // Test sequence.
   // ---------------------------------------------------------------------------
   initial begin
      {AXI_AWVALID_IN, AXI_WVALID_IN, AXI_BREADY_IN, AXI_ARVALID_IN, AXI_RREADY_IN} = 5'h00;
      {AXI_AWADDR_IN, AXI_ARADDR_IN, AXI_WDATA_IN} = '0;
      AXI_WSTRB_IN = 4'h1;
      P3_ACTIVE_IN = 2'h0;
      RESET_N_IN   = 1'b0;
      repeat (6) @(posedge CLK_SYS_IN);
      RESET_N_IN <= 1'b1;
      repeat (2) @(posedge CLK_SYS_IN);
      chk("ref ratio", 64'h1, REF_RATIO_OUT[30:0]);
      chk("fb ratio", 64'h1, FB_RATIO_OUT[20:0]);
      rdchk(IDX_A0, 8'h00);
      rdchk(IDX_PER, 8'h00);
      rdchk(IDX_STAT, 8'h03);
      $display("test reset done");
      // Every byte gets a distinct value; spare bytes get zero and S stays above 7.
      for (int i = 0; i < 40; i++) v[i] = 8'(8'h93 + i * 29);
      v[17] = 8'h40;
      v[19] = 8'h00;
      v[32] = 8'h9E;
      v[38] = 8'h00;
      v[39] = 8'h00;
      for (int i = 0; i < 40; i++) wr(11'(IDX_A0 + i), v[i]);
      for (int i = 0; i < 40; i++) rdchk(11'(IDX_A0 + i), v[i] & msk(i));
      wr(IDX_P2, 8'hFF);
      rdchk(IDX_P2, 8'hBF);
      $display("test readback done");
      repeat (2) @(posedge CLK_SYS_IN);
      chk("alpha0", {v[1], v[0]}, ALPHA0_OUT[15:0]);
      chk("alpha1", v[2][5:0], ALPHA1_EXP_OUT[5:0]);
      chk("alpha2", {v[3][0], v[2][7:6]}, ALPHA2_EXP_OUT[2:0]);
      chk("beta0", {v[5][1:0], v[4], v[3][7:1]}, BETA0_OUT[16:0]);
      chk("beta1", v[5][6:2], BETA1_EXP_OUT[4:0]);
      chk("gamma0", {v[8][0], v[7], v[6]}, GAMMA0_OUT[16:0]);
      chk("gamma1", v[8][5:1], GAMMA1_EXP_OUT[4:0]);
      chk("delta0", {v[10][6:0], v[9]}, DELTA0_OUT[14:0]);
      chk("delta1", {v[11][3:0], v[10][7]}, DELTA1_EXP_OUT[4:0]);
      chk("alpha3", v[11][7:4], ALPHA3_EXP_OUT[3:0]);
      chk("ref ratio", {v[15][5:0], v[14], v[13], v[12]} + 1, REF_RATIO_OUT[30:0]);
      chk("fb ratio", {v[18][3:0], v[17], v[16]} + 1, FB_RATIO_OUT[20:0]);
      chk("frac a", {v[21][1:0], v[20]}, FRAC_A_OUT[9:0]);
      chk("frac b", {v[22][5:0], v[21][7:4]}, FRAC_B_OUT[9:0]);
      chk("ph thr", {v[24], v[23]}, PH_THR_OUT[15:0]);
      chk("ph ns", 1'b1, PH_THR_NS_OUT[0]);
      chk("ph fill", v[25], PH_FILL_OUT[7:0]);
      chk("ph drain", v[26], PH_DRAIN_OUT[7:0]);
      chk("fr thr", {v[29], v[28], v[27]}, FR_THR_OUT[23:0]);
      chk("fr fill", v[30], FR_FILL_OUT[7:0]);
      chk("fr drain", v[31], FR_DRAIN_OUT[7:0]);
      chk("p3 ns", v[32][7], P3_PH_NS_OUT[0]);
      chk("p3 sel", v[32][2:0], P3_SEL_PRI_OUT[2:0]);
      chk("p3 prom", v[32][5:3], P3_PROM_PRI_OUT[2:0]);
      chk("p3 eff idle", v[32][2:0], P3_EFF_PRI_OUT[2:0]);
      chk("period", {v[37], v[36], v[35], v[34], v[33]}, P3_PERIOD_OUT[39:0]);
      P3_ACTIVE_IN <= 2'h1;
      repeat (2) @(posedge CLK_SYS_IN);
      chk("p3 eff active", v[32][5:3], P3_EFF_PRI_OUT[2:0]);
      $display("test fields done");
      // The second copy must move only its own slices.
      wr(11'h792, 8'hA5);
      wr(11'h793, 8'h5A);
      wr(11'h7B2, 8'h8B);
      P3_ACTIVE_IN <= 2'h2;
      repeat (2) @(posedge CLK_SYS_IN);
      chk("bank1 alpha0", 16'h5AA5, ALPHA0_OUT[31:16]);
      chk("bank0 alpha0", {v[1], v[0]}, ALPHA0_OUT[15:0]);
      chk("bank1 ns", 1'b1, P3_PH_NS_OUT[1]);
      chk("bank1 sel", 3'h3, P3_SEL_PRI_OUT[5:3]);
      chk("bank1 eff", 3'h1, P3_EFF_PRI_OUT[5:3]);
      chk("bank0 eff", v[32][2:0], P3_EFF_PRI_OUT[2:0]);
      rdchk(11'h7B2, 8'h8B);
      $display("test bank1 done");
      // A hole in the map answers with a decode error and stores nothing.
      wr(11'h685, 8'h77);
      chk("hole write resp", RESP_DEC, rsp);
      rd(11'h685);
      chk("hole read resp", RESP_DEC, rsp);
      chk("hole read data", 32'h0000_0000, rdat);
      // Status is read-only: a write answers OKAY and changes nothing.
      wr(IDX_STAT, 8'hFF);
      chk("stat write resp", RESP_OKAY, rsp);
      rdchk(IDX_STAT, 8'h02);
      // A write without lane 0 strobe answers OKAY and stores nothing.
      AXI_WSTRB_IN <= 4'h0;
      wr(IDX_A0, 8'hEE);
      AXI_WSTRB_IN <= 4'h1;
      chk("no strobe resp", RESP_OKAY, rsp);
      rdchk(IDX_A0, v[0]);
      $display("test decode done");
      final_report;
   end
endmodule
